/* File: timing_pkg.sv */
`default_nettype none
package timing_pkg;
    localparam int ADDR_W = 6;
    localparam int TW = 40;
    localparam int LINES = 8;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_SLEEP_PERIOD = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_SLEEP_COUNT = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_MAX_HOP = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_SLEEP_SELECT = 6'h0c;
    localparam logic [ADDR_W-1:0] OFS_SLEEP_OPTIONS = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_WAKE_TIME = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_SAMPLE_INTERVAL = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_LINE_CONFIG = 6'h1c;
    localparam logic [ADDR_W-1:0] OFS_COMMAND = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_CHILD_FREE = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_TX_STATUS = 6'h28;
    localparam logic [ADDR_W-1:0] OFS_POLL_TIMEOUT = 6'h2c;
    localparam logic [ADDR_W-1:0] OFS_HOLD_TIME = 6'h30;
    localparam logic [ADDR_W-1:0] OFS_NODE_STATUS = 6'h34;
    // reset values
    localparam logic [15:0] RST_SLEEP_PERIOD = 16'h0020;
    localparam logic [15:0] RST_SLEEP_COUNT = 16'h0001;
    localparam logic [7:0] RST_MAX_HOP = 8'h0a;
    localparam logic [2:0] RST_SLEEP_SELECT = 3'h0;
    localparam logic [7:0] RST_SLEEP_OPTIONS = 8'h00;
    localparam logic [15:0] RST_WAKE_TIME = 16'h1388;
    localparam logic [15:0] RST_SAMPLE_INTERVAL = 16'h0000;
    localparam logic [31:0] RST_LINE_CONFIG = 32'h0000_0000;
    // field positions and codes
    localparam int CMD_SLEEP_NOW = 0;
    localparam int CMD_TX_START = 1;
    localparam int CMD_TX_CHILD = 2;
    localparam int OPT_WAKE_BIT = 1;
    localparam int OPT_EXT_BIT = 2;
    localparam logic [2:0] SEL_CYCLIC = 3'h4;
    localparam logic [2:0] SEL_CYCLIC_PIN = 3'h5;
    localparam logic [3:0] CFG_AIN = 4'h2;
    localparam logic [3:0] CFG_DIN = 4'h3;
    // timing figures, durations in ms, multipliers and attempt counts unitless
    localparam int POLL_MULT = 3;
    localparam int SP_UNIT_MS = 10;
    localparam int POLL_MIN_MS = 5000;
    localparam int HOP_MS = 50;
    localparam int HOLD_PER_SP_MS = 12;
    localparam int HOLD_MIN_MS = 1200;
    localparam int HOLD_MAX_MS = 30000;
    localparam int TX_MULT = 3;
    localparam int MAX_ATTEMPTS = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ED_OFF, ED_SLEEP, ED_AWAKE} ed_state_type;
endpackage
`default_nettype wire

/* File: sleep_poll_timeout_control.sv */
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Operation
// [R1] parent keeps per-child time since that child's last poll
// [R2] child silent for the whole poll timeout is removed from the table
// [R3] free child-table entry count readable at any time
// [R4] poll timeout is 3 * period * count, never below 5 s
// [R5] sleep period counts in 10 ms units
// [R6] wake time and sample interval count in 1 ms units
// [R7] timeout toward an always-on router depends on hop setting only
// [R8] timeout toward a sleeping child is 3 * (50*hops + 1.2*period)
// [R9] retry on timeout, at most two more attempts, stop on ack
// [R10] awake indicator once per count cycles, or on received data
// [R11] select 4 is cyclic sleep, 5 is cyclic sleep with pin wake
// [R12] option 0x04 extends sleep, 0x06 also stays awake wake time
// [R13] extended sleep lasts period times count
// [R14] while awake, sample every interval until wake timer ends
// [R15] samples only with at least one line enabled for sampling
// [R16] sleep-now command puts the node to sleep at once
// [R17] each line has its own config; value 3 makes it digital input
// [R18] host sends settings as text or framed commands
// [R19] parent sets period and count for the longest child sleep
// [R20] all counters run from one common 1 ms tick
// [R21] buffer hold is 1.2 * period, kept within 1.2 s to 30 s
module sleep_poll_timeout_control #(
    parameter int TICK_CYCLES = timing_pkg::MS_CYCLES,
    parameter int CHILDREN = 8
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [timing_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [timing_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CHILD_JOIN,
    input wire logic CHILD_POLL,
    input wire logic [$clog2(CHILDREN)-1:0] CHILD_ID,
    input wire logic TX_ACK,
    input wire logic RX_DATA,
    input wire logic SLEEP_REQUEST_PIN,
    output logic TX_SEND,
    output logic CHILD_EXPIRED,
    output logic SAMPLE_PULSE,
    output logic AWAKE_IND,
    output logic SLEEPING,
    output logic [timing_pkg::LINES-1:0] LINE_INPUT
);
    import timing_pkg::*;
    localparam int CW = $clog2(CHILDREN);

    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return (old & ~m) | (d & m);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a <= OFS_NODE_STATUS && a[1:0] == 2'h0;
    endfunction

    function automatic logic sampled(input logic [3:0] cfg);
        return cfg == CFG_AIN || cfg == CFG_DIN;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // bus slave
    logic [15:0] sleep_period, sleep_cycle_count, wake_time;
    logic [15:0] sample_interval;
    logic [7:0] max_hop_setting, sleep_options;
    logic [2:0] sleep_select;
    logic [31:0] line_config;
    logic aw_got, w_got;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] rd_mux;

    wire aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_fire = S_AXI_WVALID && S_AXI_WREADY;
    wire ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    wire wr_do = aw_got && w_got && !S_AXI_BVALID;
    wire next_aw_got = aw_fire || (aw_got && !wr_do);
    wire next_w_got = w_fire || (w_got && !wr_do);
    wire next_bvalid = wr_do || (S_AXI_BVALID && !S_AXI_BREADY);
    wire next_rvalid = ar_fire || (S_AXI_RVALID && !S_AXI_RREADY);
    wire cmd_wr = wr_do && wr_addr == OFS_COMMAND && wr_strb[0];
    wire sleep_now = cmd_wr && wr_data[CMD_SLEEP_NOW];
    wire tx_start = cmd_wr && wr_data[CMD_TX_START];

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
        end else begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            S_AXI_AWREADY <= !next_aw_got && !next_bvalid;
            S_AXI_WREADY <= !next_w_got && !next_bvalid;
            S_AXI_BVALID <= next_bvalid;
            S_AXI_ARREADY <= !next_rvalid;
            S_AXI_RVALID <= next_rvalid;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_addr <= '0;
            wr_data <= 32'h0;
            wr_strb <= 4'h0;
            S_AXI_BRESP <= RESP_OKAY;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= RESP_OKAY;
        end else begin
            if (aw_fire) wr_addr <= S_AXI_AWADDR;
            if (w_fire) begin
                wr_data <= S_AXI_WDATA;
                wr_strb <= S_AXI_WSTRB;
            end
            if (wr_do) S_AXI_BRESP <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            if (ar_fire) begin
                S_AXI_RDATA <= rd_mux;
                S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sleep_period <= RST_SLEEP_PERIOD;
            sleep_cycle_count <= RST_SLEEP_COUNT;
            max_hop_setting <= RST_MAX_HOP;
            sleep_select <= RST_SLEEP_SELECT;
            sleep_options <= RST_SLEEP_OPTIONS;
            wake_time <= RST_WAKE_TIME;
            sample_interval <= RST_SAMPLE_INTERVAL;
            line_config <= RST_LINE_CONFIG;
        end else if (wr_do) begin
            unique case (wr_addr)
                OFS_SLEEP_PERIOD: sleep_period <=
                    16'(merge(32'(sleep_period), wr_data, wr_strb));
                OFS_SLEEP_COUNT: sleep_cycle_count <=
                    16'(merge(32'(sleep_cycle_count), wr_data, wr_strb));
                OFS_MAX_HOP: if (wr_strb[0]) max_hop_setting <= wr_data[7:0];
                OFS_SLEEP_SELECT: if (wr_strb[0]) sleep_select <= wr_data[2:0];
                OFS_SLEEP_OPTIONS: if (wr_strb[0]) sleep_options <= wr_data[7:0];
                OFS_WAKE_TIME: wake_time <=
                    16'(merge(32'(wake_time), wr_data, wr_strb));
                OFS_SAMPLE_INTERVAL: sample_interval <=
                    16'(merge(32'(sample_interval), wr_data, wr_strb));
                // one nibble per line, all eight lines in one register write
                OFS_LINE_CONFIG: line_config <=
                    merge(line_config, wr_data, wr_strb); // [R17]
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // common 1 ms tick
    logic [31:0] tick_cnt;
    logic tick;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
        end else begin
            tick <= tick_cnt == 32'(TICK_CYCLES - 1); // [R20]
            tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0
                : tick_cnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // timeouts in ms
    wire [TW-1:0] sp_w = TW'(sleep_period);
    wire [TW-1:0] cycle_prod = sp_w * TW'(sleep_cycle_count);
    wire [TW-1:0] poll_raw = cycle_prod * TW'(POLL_MULT * SP_UNIT_MS);
    wire [TW-1:0] poll_to = (poll_raw < TW'(POLL_MIN_MS))
        ? TW'(POLL_MIN_MS) : poll_raw; // [R4] [R5]
    wire [TW-1:0] hold_raw = sp_w * TW'(HOLD_PER_SP_MS);
    wire [TW-1:0] hold_ms = (hold_raw < TW'(HOLD_MIN_MS)) ? TW'(HOLD_MIN_MS)
        : (hold_raw > TW'(HOLD_MAX_MS)) ? TW'(HOLD_MAX_MS) : hold_raw; // [R21]
    wire [TW-1:0] route_ms = TW'(max_hop_setting) * TW'(HOP_MS);
    wire [TW-1:0] tx_router_to = TW'(TX_MULT) * route_ms; // [R7]
    wire [TW-1:0] tx_child_to = TW'(TX_MULT) * (route_ms + hold_raw); // [R8]

    poll_floor_a: assert property ( // [R4]
        poll_to >= TW'(POLL_MIN_MS)
        && (poll_raw >= TW'(POLL_MIN_MS) -> poll_to == poll_raw))
        else $error("poll timeout off");
    hold_range_a: assert property ( // [R21]
        hold_ms >= TW'(HOLD_MIN_MS) && hold_ms <= TW'(HOLD_MAX_MS))
        else $error("hold time out of range");
    router_to_a: assert property ( // [R7]
        tx_router_to == TW'(TX_MULT * HOP_MS) * TW'(max_hop_setting))
        else $error("router timeout off");

    ////////////////////////////////////////////////////////////////////
    // child table
    logic [CHILDREN-1:0] child_valid, expire;
    logic [TW-1:0] child_age [CHILDREN];
    logic [CW:0] child_free;

    for (genvar i = 0; i < CHILDREN; i++) begin : g_child
        wire hit = CHILD_ID == CW'(i);
        wire touch = (CHILD_JOIN || CHILD_POLL) && hit;
        assign expire[i] = child_valid[i] && tick && !touch
            && child_age[i] + TW'(1) >= poll_to; // [R2]
        always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                child_valid[i] <= 1'b0;
                child_age[i] <= '0;
            end else if (CHILD_JOIN && hit) begin
                child_valid[i] <= 1'b1;
                child_age[i] <= '0;
            end else if (CHILD_POLL && hit) begin
                child_age[i] <= '0; // [R1]
            end else if (expire[i]) begin
                child_valid[i] <= 1'b0; // [R2]
            end else if (tick && child_valid[i]) begin
                child_age[i] <= child_age[i] + TW'(1); // [R1]
            end
        end
        child_expire_a: assert property ( // [R2]
            expire[i] |=> !child_valid[i])
            else $error("silent child kept");
        child_poll_a: assert property ( // [R1]
            CHILD_POLL && hit && child_valid[i] |=> child_age[i] == '0)
            else $error("poll time not recorded");
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            child_free <= (CW+1)'(CHILDREN);
            CHILD_EXPIRED <= 1'b0;
        end else begin
            child_free <= (CW+1)'($countones(~child_valid)); // [R3]
            CHILD_EXPIRED <= |expire;
        end
    end

    free_count_a: assert property ( // [R3]
        ##1 child_free == (CW+1)'($countones(~$past(child_valid))))
        else $error("free count wrong");

    ////////////////////////////////////////////////////////////////////
    // transmission timeout and retries
    logic tx_busy, tx_to_child, tx_ok, tx_fail;
    logic [1:0] tx_attempt;
    logic [TW-1:0] tx_cnt;
    wire [TW-1:0] tx_limit = tx_to_child ? tx_child_to : tx_router_to;
    wire tx_launch = tx_start && !tx_busy;
    wire tx_expire = tx_busy && !TX_ACK && tick
        && tx_cnt + TW'(1) >= tx_limit;
    wire tx_retry = tx_expire && tx_attempt < 2'(MAX_ATTEMPTS); // [R9]

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_busy <= 1'b0;
            tx_to_child <= 1'b0;
            tx_ok <= 1'b0;
            tx_fail <= 1'b0;
            tx_attempt <= 2'h0;
            tx_cnt <= '0;
        end else if (tx_launch) begin
            tx_busy <= 1'b1;
            tx_to_child <= wr_data[CMD_TX_CHILD];
            tx_ok <= 1'b0;
            tx_fail <= 1'b0;
            tx_attempt <= 2'h1;
            tx_cnt <= '0;
        end else if (tx_busy && TX_ACK) begin
            tx_busy <= 1'b0; // [R9]
            tx_ok <= 1'b1;
        end else if (tx_retry) begin
            tx_attempt <= tx_attempt + 2'h1;
            tx_cnt <= '0;
        end else if (tx_expire) begin
            tx_busy <= 1'b0;
            tx_fail <= 1'b1;
        end else if (tx_busy && tick) begin
            tx_cnt <= tx_cnt + TW'(1);
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) TX_SEND <= 1'b0;
        else TX_SEND <= tx_launch || tx_retry; // [R9]
    end

    tx_limit_a: assert property ( // [R9]
        (tx_fail -> !tx_busy && tx_attempt == 2'(MAX_ATTEMPTS))
        && (tx_busy -> tx_attempt != 2'h0))
        else $error("too many attempts");
    ack_stop_a: assert property ( // [R9]
        tx_busy && TX_ACK |=> !tx_busy && tx_ok && !TX_SEND)
        else $error("ack did not stop retries");

    ////////////////////////////////////////////////////////////////////
    // end device sleep cycle
    ed_state_type ed_state;
    logic [TW-1:0] ed_cnt;
    logic [15:0] cyc_cnt, wake_cnt, samp_cnt;
    logic stay;
    logic [LINES-1:0] line_samp;

    for (genvar j = 0; j < LINES; j++) begin : g_line
        assign line_samp[j] = sampled(line_config[4*j +: 4]);
        always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) LINE_INPUT[j] <= 1'b0;
            else LINE_INPUT[j] <= line_config[4*j +: 4] == CFG_DIN; // [R17]
        end
    end

    wire cyclic = sleep_select == SEL_CYCLIC
        || sleep_select == SEL_CYCLIC_PIN; // [R11]
    wire pin_wake = sleep_select == SEL_CYCLIC_PIN
        && !SLEEP_REQUEST_PIN; // [R11]
    wire ext = sleep_options[OPT_EXT_BIT]; // [R12]
    wire stay_opt = ext && sleep_options[OPT_WAKE_BIT]; // [R12]
    wire [TW-1:0] sleep_ms = ext ? cycle_prod * TW'(SP_UNIT_MS)
        : sp_w * TW'(SP_UNIT_MS); // [R5] [R13]
    wire wake_now = cyclic && ed_state == ED_SLEEP
        && (pin_wake || (tick && ed_cnt + TW'(1) >= sleep_ms));
    wire show = ext || cyc_cnt + 16'h1 >= sleep_cycle_count; // [R10]
    wire wake_end = ed_state == ED_AWAKE && tick && !RX_DATA
        && (!stay || wake_cnt + 16'h1 >= wake_time); // [R6] [R14]
    wire go_sleep = cyclic && ed_state == ED_AWAKE
        && (sleep_now || wake_end); // [R16]
    wire samp_en = sample_interval != 16'h0 && |line_samp; // [R15]

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ed_state <= ED_OFF;
            ed_cnt <= '0;
            cyc_cnt <= 16'h0;
            wake_cnt <= 16'h0;
            stay <= 1'b0;
        end else if (!cyclic) begin
            ed_state <= ED_OFF;
        end else begin
            unique case (ed_state)
                ED_OFF: begin
                    ed_state <= ED_SLEEP;
                    ed_cnt <= '0;
                end
                ED_SLEEP: begin
                    if (wake_now) begin
                        ed_state <= ED_AWAKE;
                        wake_cnt <= 16'h0;
                        stay <= stay_opt; // [R12]
                        cyc_cnt <= show ? 16'h0 : cyc_cnt + 16'h1;
                    end else if (tick) begin
                        ed_cnt <= ed_cnt + TW'(1); // [R13]
                    end
                end
                ED_AWAKE: begin
                    if (go_sleep) begin
                        ed_state <= ED_SLEEP; // [R16]
                        ed_cnt <= '0;
                    end else if (RX_DATA) begin
                        stay <= 1'b1;
                        wake_cnt <= 16'h0;
                    end else if (tick) begin
                        wake_cnt <= wake_cnt + 16'h1; // [R6]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            AWAKE_IND <= 1'b0;
            SLEEPING <= 1'b0;
        end else if (!cyclic) begin
            AWAKE_IND <= 1'b1;
            SLEEPING <= 1'b0;
        end else begin
            if (wake_now) AWAKE_IND <= show; // [R10]
            else if (go_sleep || ed_state != ED_AWAKE) AWAKE_IND <= 1'b0;
            else if (RX_DATA) AWAKE_IND <= 1'b1; // [R10]
            SLEEPING <= !wake_now && (ed_state != ED_AWAKE || go_sleep);
        end
    end

    // one sample on wake, then one per interval while awake
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            samp_cnt <= 16'h0;
            SAMPLE_PULSE <= 1'b0;
        end else if (wake_now) begin
            samp_cnt <= 16'h0;
            SAMPLE_PULSE <= samp_en; // [R14] [R15]
        end else if (ed_state == ED_AWAKE && !go_sleep && tick && samp_en) begin
            SAMPLE_PULSE <= samp_cnt + 16'h1 >= sample_interval; // [R14]
            samp_cnt <= (samp_cnt + 16'h1 >= sample_interval) ? 16'h0
                : samp_cnt + 16'h1; // [R6]
        end else begin
            SAMPLE_PULSE <= 1'b0;
        end
    end

    sample_gate_a: assert property ( // [R15]
        SAMPLE_PULSE |-> $past(samp_en) && $past(cyclic))
        else $error("sample without enabled line");
    sleep_now_a: assert property ( // [R16]
        sleep_now && cyclic && ed_state == ED_AWAKE
        |=> ed_state == ED_SLEEP && SLEEPING && !AWAKE_IND)
        else $error("sleep command ignored");
    ext_sleep_a: assert property ( // [R13]
        wake_now && !pin_wake && ext
        |-> ed_cnt + TW'(1) >= cycle_prod * TW'(SP_UNIT_MS))
        else $error("extended sleep too short");
    ind_cadence_a: assert property ( // [R10]
        wake_now && !ext && cyc_cnt + 16'h1 < sleep_cycle_count
        |=> !AWAKE_IND)
        else $error("awake indicator too often");

    ////////////////////////////////////////////////////////////////////
    // read selection
    assign rd_mux =
        (S_AXI_ARADDR == OFS_SLEEP_PERIOD) ? {16'h0, sleep_period}
        : (S_AXI_ARADDR == OFS_SLEEP_COUNT) ? {16'h0, sleep_cycle_count}
        : (S_AXI_ARADDR == OFS_MAX_HOP) ? {24'h0, max_hop_setting}
        : (S_AXI_ARADDR == OFS_SLEEP_SELECT) ? {29'h0, sleep_select}
        : (S_AXI_ARADDR == OFS_SLEEP_OPTIONS) ? {24'h0, sleep_options}
        : (S_AXI_ARADDR == OFS_WAKE_TIME) ? {16'h0, wake_time}
        : (S_AXI_ARADDR == OFS_SAMPLE_INTERVAL) ? {16'h0, sample_interval}
        : (S_AXI_ARADDR == OFS_LINE_CONFIG) ? line_config
        : (S_AXI_ARADDR == OFS_CHILD_FREE) ? 32'(child_free) // [R3]
        : (S_AXI_ARADDR == OFS_TX_STATUS)
            ? {28'h0, tx_attempt, tx_fail, tx_ok} | {31'h0, 1'b0}
                | {tx_busy, 31'h0}
        : (S_AXI_ARADDR == OFS_POLL_TIMEOUT) ? poll_to[31:0]
        : (S_AXI_ARADDR == OFS_HOLD_TIME) ? hold_ms[31:0]
        : (S_AXI_ARADDR == OFS_NODE_STATUS)
            ? {28'h0, stay, AWAKE_IND, ed_state} : 32'h0;

endmodule // sleep_poll_timeout_control
`default_nettype wire

/* File: radio_peer_model.sv */
`timescale 1ns/100ps
`default_nettype none
module radio_peer_model (
    input wire logic clk,
    input wire logic tx_send,
    input wire logic answer,
    output logic tx_ack = 1'b0
);
    logic [2:0] dly = 3'h0;
    always @(posedge clk) begin
        dly <= {dly[1:0], tx_send & answer};
        tx_ack <= dly[2];
    end
endmodule // radio_peer_model
`default_nettype wire

/* File: sleep_poll_timeout_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module sleep_poll_timeout_control_tb;
    import timing_pkg::*;
    logic CLK = '0, RESET_N = '0, ans = '0, CHILD_JOIN = '0, CHILD_POLL = '0;
    logic S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_BREADY = '0;
    logic S_AXI_ARVALID = '0, S_AXI_RREADY = '0, RX_DATA = '0;
    logic SLEEP_REQUEST_PIN = 1'b1, S_AXI_AWREADY, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, TX_ACK, TX_SEND;
    logic CHILD_EXPIRED, SAMPLE_PULSE, AWAKE_IND, SLEEPING;
    logic [5:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [3:0] S_AXI_WSTRB = 4'hf;
    logic [2:0] CHILD_ID = 3'h2;
    logic [7:0] LINE_INPUT;
    int mismatches = 0, comparisons = 0, n_tx = 0, n_exp = 0, n_smp = 0, k;
    int n_ind = 0;
    logic ind_q = 1'b0;
    sleep_poll_timeout_control #(.TICK_CYCLES(4)) dut (.*);
    radio_peer_model peer (.clk(CLK), .tx_send(TX_SEND), .answer(ans),
        .tx_ack(TX_ACK));
    always #5 CLK = ~CLK;
    always @(posedge CLK) n_tx <= n_tx + TX_SEND;
    always @(posedge CLK) n_exp <= n_exp + CHILD_EXPIRED;
    always @(posedge CLK) n_smp <= n_smp + SAMPLE_PULSE;
    always @(posedge CLK) ind_q <= AWAKE_IND;
    always @(posedge CLK) n_ind <= n_ind + int'(AWAKE_IND && !ind_q);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [5:0] a, logic [31:0] v);
        @(posedge CLK);
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} <= {a, a, v};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {w, w, w};
        {S_AXI_ARVALID, S_AXI_RREADY} <= {!w, !w};
        do begin
            @(posedge CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (!(w ? S_AXI_BVALID : S_AXI_RVALID));
        {S_AXI_BREADY, S_AXI_RREADY} <= 2'b00;
        if (!w) chk(S_AXI_RDATA, v);
    endtask
    task automatic conclude(input int t);
        mismatches += t;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial #600000 conclude(1);
    initial begin
        repeat (3) @(posedge CLK);
        RESET_N <= 1'b1;
        acc(0, 6'h3c, 32'h0);
        chk(32'(S_AXI_RRESP), 32'(RESP_SLVERR));
        CHILD_JOIN <= 1'b1;
        @(posedge CLK);
        CHILD_JOIN <= 1'b0;
        k = n_exp;
        acc(0, OFS_CHILD_FREE, 32'h7);
        repeat (10000) @(posedge CLK);
        CHILD_POLL <= 1'b1;
        @(posedge CLK);
        CHILD_POLL <= 1'b0;
        repeat (19900) @(posedge CLK);
        chk(n_exp - k, 0);
        repeat (300) @(posedge CLK);
        chk(n_exp - k, 1);
        acc(0, OFS_CHILD_FREE, 32'h8);
        $display("expiry test done");
        acc(1, OFS_SLEEP_COUNT, 32'h3);
        chk(32'(S_AXI_BRESP), 32'(RESP_OKAY));
        acc(1, OFS_SLEEP_PERIOD, 32'h9c4);
        acc(0, OFS_POLL_TIMEOUT, 32'h36ee8);
        acc(0, OFS_HOLD_TIME, 32'h7530);
        acc(1, OFS_MAX_HOP, 32'h1);
        acc(1, OFS_SLEEP_PERIOD, 32'h1);
        k = n_tx;
        acc(1, OFS_COMMAND, 32'h2);
        repeat (2000) @(posedge CLK);
        chk(n_tx - k, 3);
        acc(0, OFS_TX_STATUS, 32'he);
        acc(1, OFS_COMMAND, 32'h6);
        repeat (680) @(posedge CLK);
        chk(n_tx - k, 4);
        ans <= 1'b1;
        repeat (1700) @(posedge CLK);
        chk(n_tx - k, 5);
        acc(0, OFS_TX_STATUS, 32'h9);
        $display("transmit test done");
        acc(1, OFS_LINE_CONFIG, 32'h30);
        acc(1, OFS_SAMPLE_INTERVAL, 32'h2);
        chk(LINE_INPUT, 8'h02);
        acc(1, OFS_SLEEP_OPTIONS, 32'h6);
        acc(1, OFS_SLEEP_SELECT, 32'h5);
        @(posedge CLK);
        chk(32'(SLEEPING), 32'h1);
        SLEEP_REQUEST_PIN <= 1'b0;
        repeat (3) @(posedge CLK);
        chk(32'(SLEEPING), 32'h0);
        chk(32'(AWAKE_IND), 32'h1);
        k = n_smp;
        repeat (80) @(posedge CLK);
        chk((n_smp - k) inside {[9:12]}, 1'b1);
        SLEEP_REQUEST_PIN <= 1'b1;
        acc(1, OFS_COMMAND, 32'h1);
        chk(32'(SLEEPING), 32'h1);
        chk(32'(AWAKE_IND), 32'h0);
        repeat (100) @(posedge CLK);
        chk(32'(SLEEPING), 32'h1);
        repeat (40) @(posedge CLK);
        chk(32'(SLEEPING), 32'h0);
        acc(1, OFS_SLEEP_OPTIONS, 32'h0);
        acc(1, OFS_COMMAND, 32'h1);
        k = n_ind;
        repeat (330) @(posedge CLK);
        chk(n_ind - k, 2);
        $display("sleep test done");
        conclude(0);
    end
endmodule // sleep_poll_timeout_control_tb
`default_nettype wire
